// ===== rtl/ls_exec_regs.svh
// Constants for the load, store and zero execution unit.
`ifndef LS_EXEC_REGS_SVH
`define LS_EXEC_REGS_SVH
`define PC_STEP_WORD 24'h000004
`define PC_STEP_HALF 24'h000002
`define SCRATCH_DEPTH 256
`define LF_LAST_REG 3'h7
`define CC_CLEAR_RESULT 4'h1
`define IDX_LO 8
`define IDX_HI 15
`endif

// ===== rtl/ls_exec_pkg.sv
// Types shared by the load, store and zero execution unit.
package ls_exec_pkg;
  typedef enum logic [3:0] {
    load_address_op = 4'h0,
    load_register_file_op = 4'h1,
    store_halfword_op = 4'h2,
    store_word_op = 4'h3,
    store_doubleword_op = 4'h4,
    store_masked_byte_op = 4'h5,
    store_masked_halfword_op = 4'h6,
    store_masked_word_op = 4'h7,
    zero_memory_byte_op = 4'h8,
    zero_memory_halfword_op = 4'h9,
    zero_memory_word_op = 4'hA,
    zero_memory_doubleword_op = 4'hB,
    register_clear_op = 4'hC,
    scratchpad_to_register_op = 4'hD,
    transfer_op = 4'hE,
    no_op = 4'hF
  } op_t;

  typedef struct packed {
    logic [5:0] opcode;
    logic [2:0] dest;
    logic [2:0] src;
    logic [3:0] aug;
  } rr_half_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [23:0] addr;
    logic [3:0] be;
    logic [31:0] data;
  } mem_req_t;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_mem = 3'b001,
    st_wait = 3'b010,
    st_spad = 3'b011,
    st_done = 3'b100
  } state_t;
endpackage : ls_exec_pkg

// ===== rtl/scratch_mem.sv
// Scratchpad word memory with registered read data.
`timescale 1ns/1ps
module scratch_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock and enable
  input wire logic ref_clk,
  input wire logic ce,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [DEPTH];

  initial
  begin
    if (DEPTH != (1 << AW))
      $error("scratch_mem depth must equal two to the address width");
  end

  always_ff @(posedge ref_clk)
  begin
    if (ce && wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (ce)
      rd_data <= mem[rd_addr];
  end
endmodule : scratch_mem

// ===== rtl/ls_exec_unit.sv
// Execution unit for load address, register file, stores and zeroing.
// Functional notes
// [RULE1] Load address writes EA; bits 0-7 zero, bits 8-11 extended index.
// [RULE2] Bit 12 is indirect flag in 512 KB mode, EA bit extended.
// [RULE3] Register-file load copies words into successive registers through 7.
// [RULE4] Software keeps register-file addresses from carrying out of bit 27.
// [RULE5] Store halfword writes right halfword of register to memory.
// [RULE6] Store word writes the full register to the word address.
// [RULE7] Store doubleword writes R+1 to low word first, then R.
// [RULE8] Masked byte store ANDs bits 24-31 with mask low byte.
// [RULE9] Masked halfword store ANDs bits 16-31 with mask low halfword.
// [RULE10] Masked word store ANDs full register with mask.
// [RULE11] Zero byte clears one byte, other three unchanged.
// [RULE12] Zero halfword clears one halfword, other unchanged.
// [RULE13] Zero word clears the whole addressed word.
// [RULE14] Zero doubleword clears both words of the doubleword.
// [RULE15] Address, store and zero operations keep condition codes.
// [RULE16] Register clear XORs the two named registers and writes back.
// [RULE17] Register clear sets condition code to 0001.
// [RULE18] Transfer halfword: opcode 0-5, dest 6-8, source 9-11, aug 12-15.
// [RULE19] Register transfers set condition code from result sign.
// [RULE20] Scratchpad read indexed by source bits 8-15 into destination.
// [RULE21] Scratchpad read is privileged halfword, condition code kept.
// [RULE22] Scratchpad holds 256 words selected by an eight-bit index.
// [RULE23] Unprivileged scratchpad read raises a privilege trap instead.
// [RULE24] Program counter advances four after words, two after halfwords.
`timescale 1ns/1ps
`include "ls_exec_regs.svh"
module ls_exec_unit
  import ls_exec_pkg::*;
#(
  parameter int SPAD_DEPTH = `SCRATCH_DEPTH
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Instruction issue
  input wire logic start,
  input wire op_t op,
  input wire logic [2:0] reg_sel,
  input wire rr_half_t half_instr,
  input wire logic half_format,
  input wire logic [23:0] eff_addr,
  input wire logic [3:0] ext_index,
  input wire logic indirect_flag,
  input wire logic extended_mode,
  input wire logic privileged,
  input wire logic [23:0] pc_in,
  // Register file read view
  input wire logic [255:0] gpr_flat,
  // Memory answer
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Memory request
  output mem_req_t mem_req,
  // Register write-back
  output logic gpr_we,
  output logic [2:0] gpr_waddr,
  output logic [31:0] gpr_wdata,
  // Status
  output logic [3:0] cond_code,
  output logic cc_we,
  output logic [23:0] pc_out,
  output logic busy,
  output logic done,
  output logic priv_trap
);
  state_t state;
  op_t cur_op;
  logic [23:0] addr;
  logic [2:0] reg_idx;
  logic second;
  logic [31:0] gpr [8];
  logic [31:0] mask;
  logic [31:0] spad_rdata;
  logic [7:0] spad_index;
  logic [31:0] next_data;
  logic [3:0] next_be;
  logic [31:0] rv;
  logic [31:0] rv1;
  logic [23:0] step;
  rr_half_t hi;

  initial
  begin
    if (SPAD_DEPTH != `SCRATCH_DEPTH)
      $error("ls_exec_unit supports only a 256 word scratchpad");
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_gpr
      assign gpr[gi] = gpr_flat[gi*32 +: 32];
    end
  endgenerate

  assign mask = gpr[4];
  assign hi = half_instr;  // [RULE18]
  assign rv = gpr[reg_idx];
  assign rv1 = gpr[reg_idx + 3'h1];
  // Index taken from source register bits 8-15 (big-endian numbering).
  assign spad_index = gpr[hi.src][31-`IDX_LO -: 8];  // [RULE20] [RULE22]
  assign step = half_format ? `PC_STEP_HALF : `PC_STEP_WORD;

  // The write port is tied off; this unit only reads the scratchpad.
  scratch_mem #(
    .DEPTH(`SCRATCH_DEPTH),
    .AW(8)
  ) u_spad (
    .ref_clk(ref_clk),
    .ce(ce),
    .wr_en(1'b0),
    .wr_addr(8'h00),
    .wr_data(32'h00000000),
    .rd_addr(spad_index),
    .rd_data(spad_rdata)
  );

  // Byte lanes: byte 0 of a word is the most significant (bits 0-7).
  always_comb
  begin
    next_data = 32'h00000000;
    next_be = 4'h0;
    case (cur_op)
      store_word_op:
      begin
        next_data = rv;  // [RULE6]
        next_be = 4'hF;
      end
      store_doubleword_op:
      begin
        next_data = second ? rv : rv1;  // [RULE7]
        next_be = 4'hF;
      end
      store_masked_word_op:
      begin
        next_data = rv & mask;  // [RULE10]
        next_be = 4'hF;
      end
      store_halfword_op:
      begin
        next_data = {2{rv[15:0]}};  // [RULE5]
        next_be = addr[1] ? 4'h3 : 4'hC;
      end
      store_masked_halfword_op:
      begin
        next_data = {2{rv[15:0] & mask[15:0]}};  // [RULE9]
        next_be = addr[1] ? 4'h3 : 4'hC;
      end
      store_masked_byte_op:
      begin
        next_data = {4{rv[7:0] & mask[7:0]}};  // [RULE8]
        next_be = 4'(4'h8 >> addr[1:0]);
      end
      zero_memory_byte_op:
        next_be = 4'(4'h8 >> addr[1:0]);  // [RULE11]
      zero_memory_halfword_op:
        next_be = addr[1] ? 4'h3 : 4'hC;  // [RULE12]
      zero_memory_word_op, zero_memory_doubleword_op:
        next_be = 4'hF;  // [RULE13] [RULE14]
      default:
      begin
        next_data = 32'h00000000;
        next_be = 4'h0;
      end
    endcase
  end

  // Sequencer and memory request.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= st_idle;
      cur_op <= no_op;
      addr <= 24'h000000;
      reg_idx <= 3'h0;
      second <= 1'b0;
      mem_req <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      priv_trap <= 1'b0;
      pc_out <= 24'h000000;
    end
    else if (ce)
    begin
      done <= 1'b0;
      priv_trap <= 1'b0;
      case (state)
        st_idle:
          if (start)
          begin
            cur_op <= op;
            addr <= eff_addr;
            reg_idx <= half_format ? hi.dest : reg_sel;
            second <= 1'b0;
            busy <= 1'b1;
            pc_out <= pc_in + step;  // [RULE24]
            case (op)
              load_address_op, register_clear_op, transfer_op, no_op:
                state <= st_done;
              scratchpad_to_register_op:
                if (!privileged)
                begin
                  state <= st_done;
                  priv_trap <= 1'b1;  // [RULE23]
                  pc_out <= pc_in;
                end
                else
                  state <= st_spad;
              default:
                state <= st_mem;
            endcase
          end
        st_mem:
        begin
          mem_req.req <= 1'b1;
          mem_req.wr <= (cur_op != load_register_file_op);
          mem_req.data <= next_data;
          mem_req.be <= next_be;
          if (cur_op == store_doubleword_op
              || cur_op == zero_memory_doubleword_op)
            mem_req.addr <= {addr[23:3], ~second, 2'b00};  // [RULE7]
          else if (cur_op == load_register_file_op)
            mem_req.addr <= {addr[23:2], 2'b00};
          else
            mem_req.addr <= addr;
          state <= st_wait;
        end
        st_wait:
          if (mem_ack)
          begin
            mem_req <= '0;
            if (cur_op == load_register_file_op && reg_idx != `LF_LAST_REG)
            begin
              addr <= addr + 24'h000004;  // [RULE3] [RULE4]
              reg_idx <= reg_idx + 3'h1;
              state <= st_mem;
            end
            else if ((cur_op == store_doubleword_op
                      || cur_op == zero_memory_doubleword_op) && !second)
            begin
              second <= 1'b1;
              state <= st_mem;
            end
            else
              state <= st_done;
          end
        st_spad:
          state <= st_done;
        st_done:
        begin
          busy <= 1'b0;
          done <= 1'b1;
          state <= st_idle;
        end
        default:
          state <= st_idle;
      endcase
    end
  end

  // Register write-back.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gpr_we <= 1'b0;
      gpr_waddr <= 3'h0;
      gpr_wdata <= 32'h00000000;
    end
    else if (ce)
    begin
      gpr_we <= 1'b0;
      if (state == st_wait && mem_ack && cur_op == load_register_file_op)
      begin
        gpr_we <= 1'b1;  // [RULE3]
        gpr_waddr <= reg_idx;
        gpr_wdata <= mem_rdata;
      end
      else if (state == st_spad)
      begin
        gpr_we <= 1'b1;  // [RULE20]
        gpr_waddr <= reg_idx;
        gpr_wdata <= spad_rdata;
      end
      else if (state == st_idle && start)
      begin
        case (op)
          load_address_op:
          begin
            gpr_we <= 1'b1;  // [RULE1]
            gpr_waddr <= reg_sel;
            gpr_wdata <= {8'h00, ext_index,
                          extended_mode ? eff_addr[19] : indirect_flag,
                          eff_addr[18:0]};  // [RULE2]
          end
          register_clear_op:
          begin
            gpr_we <= 1'b1;  // [RULE16]
            gpr_waddr <= hi.dest;
            gpr_wdata <= gpr[hi.dest] ^ gpr[hi.src];
          end
          transfer_op:
          begin
            gpr_we <= 1'b1;
            gpr_waddr <= hi.dest;
            gpr_wdata <= gpr[hi.src];
          end
          default:
            gpr_we <= 1'b0;
        endcase
      end
    end
  end

  // Condition codes; memory, address and scratchpad operations leave them.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cond_code <= 4'h0;
      cc_we <= 1'b0;
    end
    else if (ce)
    begin
      cc_we <= 1'b0;  // [RULE15] [RULE21]
      if (state == st_idle && start && op == register_clear_op)
      begin
        cond_code <= `CC_CLEAR_RESULT;  // [RULE17]
        cc_we <= 1'b1;
      end
      else if (state == st_idle && start && op == transfer_op)
      begin
        cc_we <= 1'b1;  // [RULE19]
        cond_code <= {1'b0,
                      !gpr[hi.src][31] && |gpr[hi.src],
                      gpr[hi.src][31],
                      ~|gpr[hi.src]};
      end
    end
  end
endmodule : ls_exec_unit

// ===== verification/ls_exec_unit_monitor.sv
// Port-level checks on the load, store and zero execution unit.
`timescale 1ns/1ps
module ls_exec_monitor
  import ls_exec_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Issue
  input wire logic ce,
  input wire logic start,
  input wire op_t op,
  input wire logic half_format,
  input wire logic privileged,
  input wire logic [23:0] pc_in,
  // Results
  input wire mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic gpr_we,
  input wire logic [31:0] gpr_wdata,
  input wire logic [3:0] cond_code,
  input wire logic cc_we,
  input wire logic [23:0] pc_out,
  input wire logic busy,
  input wire logic done,
  input wire logic priv_trap
);
  op_t c_op;
  logic c_half;
  logic c_priv;
  logic [23:0] c_pc;
  logic [31:0] lane;
  assign lane = {{8{mem_req.be[3]}}, {8{mem_req.be[2]}},
    {8{mem_req.be[1]}}, {8{mem_req.be[0]}}};
  // Operands are captured at issue, since the issuer may move on early.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      c_op <= no_op;
      c_half <= 1'b0;
      c_priv <= 1'b0;
      c_pc <= 24'h000000;
    end
    else if (ce && start && !busy)
    begin
      c_op <= op;
      c_half <= half_format;
      c_priv <= privileged;
      c_pc <= pc_in;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_taken;
    ce && start && !busy;
  endsequence
  sequence s_finish;
    ##[1:600] (done || priv_trap);
  endsequence
  a_busy_issue: assert property (s_taken |=> busy)
    else $error("busy did not rise after issue");
  a_op_finish: assert property (s_taken |-> s_finish)
    else $error("operation did not finish in time");
  a_cc_kept: assert property (cc_we |->
    c_op inside {register_clear_op, transfer_op})
    else $error("condition code written by a keeping operation");
  a_clear_cc: assert property (cc_we && c_op == register_clear_op |->
    cond_code == 4'h1 && gpr_we && gpr_wdata == 32'h0)
    else $error("register clear result or code wrong");
  a_la_top: assert property (gpr_we && c_op == load_address_op |->
    gpr_wdata[31:24] == 8'h00)
    else $error("load address top byte not cleared");
  a_trap_quiet: assert property (priv_trap |-> !gpr_we && !mem_req.req)
    else $error("trap came with a transfer");
  a_zero_data: assert property (mem_req.req && c_op inside
    {zero_memory_byte_op, zero_memory_halfword_op, zero_memory_word_op,
    zero_memory_doubleword_op} |-> mem_req.wr
    && (mem_req.data & lane) == 32'h0)
    else $error("zeroing wrote nonzero data");
  a_req_hold: assert property (mem_req.req && !mem_ack |=>
    $stable(mem_req))
    else $error("memory request changed before answer");
  a_pc_step: assert property (done && !(c_op == scratchpad_to_register_op
    && !c_priv) |-> pc_out == c_pc + (c_half ? 24'h2 : 24'h4))
    else $error("program counter step wrong");
endmodule : ls_exec_monitor

bind ls_exec_unit ls_exec_monitor mon (.ref_clk(ref_clk), .rst(rst),
  .ce(ce), .start(start), .op(op), .half_format(half_format),
  .privileged(privileged), .pc_in(pc_in), .mem_req(mem_req),
  .mem_ack(mem_ack), .gpr_we(gpr_we), .gpr_wdata(gpr_wdata),
  .cond_code(cond_code), .cc_we(cc_we), .pc_out(pc_out), .busy(busy),
  .done(done), .priv_trap(priv_trap));

// ===== verification/mem_model.sv
// Behavioural main memory that answers the unit's requests.
`timescale 1ns/1ps
module mem_model
  import ls_exec_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Request and answer delay
  input wire mem_req_t mem_req,
  input wire logic [2:0] lat,
  // Answer
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [64];
  logic [2:0] cnt;
  // Read data flips between answers so a stale sample never passes.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_ack <= 1'b0;
      cnt <= 3'h0;
      mem_rdata <= 32'hFFFFFFFF;
      for (int i = 0; i < 64; i++)
        mem[i] <= 32'h5A5A0000 + 32'(i);
    end
    else if (ce && (mem_ack || !mem_req.req || cnt < lat))
    begin
      mem_ack <= 1'b0;
      cnt <= (mem_ack || !mem_req.req) ? 3'h0 : cnt + 3'h1;
      mem_rdata <= ~mem_rdata;
    end
    else if (ce)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_req.addr[7:2]];
      for (int b = 0; b < 4; b++)
        if (mem_req.wr && mem_req.be[b])
          mem[mem_req.addr[7:2]][b*8+:8] <= mem_req.data[b*8+:8];
    end
  end
endmodule : mem_model

// ===== verification/load_store_zero_exec_unit_test.sv
// Self-checking bench for the load, store and zero execution unit.
`timescale 1ns/1ps
module load_store_zero_exec_unit_test
  import ls_exec_pkg::*;
;
  logic ref_clk = 0, rst = 1, start = 0, half_format = 0, indirect_flag = 0;
  logic extended_mode = 0, privileged = 1, mem_ack, gpr_we, cc_we, busy;
  logic done, priv_trap, ce = 1;
  op_t op = no_op;
  logic [2:0] reg_sel = 0, lat = 0, gpr_waddr;
  rr_half_t half_instr = '0;
  logic [23:0] eff_addr = 0, pc_in = 0, pc_out, a;
  logic [3:0] ext_index = 0, cond_code;
  logic [7:0][31:0] gpr = '0;
  logic [31:0] mem_rdata, gpr_wdata, v;
  mem_req_t mem_req;
  logic [63:0] q_g[$], q_m[$], q_c[$], q_p[$];
  integer n_mismatch = 0, tests_run = 0, seed = 30;
  always #12.5 ref_clk = ~ref_clk;
  ls_exec_unit uut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .start(start), .op(op), .reg_sel(reg_sel), .half_instr(half_instr),
    .half_format(half_format), .eff_addr(eff_addr), .ext_index(ext_index),
    .indirect_flag(indirect_flag), .extended_mode(extended_mode),
    .privileged(privileged), .pc_in(pc_in), .gpr_flat(gpr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .gpr_we(gpr_we), .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata),
    .cond_code(cond_code), .cc_we(cc_we), .pc_out(pc_out), .busy(busy),
    .done(done), .priv_trap(priv_trap));
  mem_model mem (.ref_clk(ref_clk), .rst(rst), .ce(ce), .mem_req(mem_req),
    .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  function automatic logic [63:0] pop(ref logic [63:0] q[$]);
    return q.size() > 0 ? q.pop_front() : 'x;
  endfunction : pop
  task automatic cmp(input string n, input logic [63:0] e, g);
    tests_run++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic final_report;
    n_mismatch += q_g.size() + q_m.size() + q_c.size() + q_p.size();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Results are taken at the edge, before that edge's updates land.
  // A frozen edge is skipped, since every pulse stands on through it.
  always @(posedge ref_clk)
  begin
    if (ce && gpr_we === 1'b1)
      cmp("gpr", pop(q_g), 64'({gpr_waddr, gpr_wdata}));
    if (ce && mem_req.req === 1'b1 && mem_ack === 1'b1
        && mem_req.wr === 1'b1)
      cmp("mem", pop(q_m), 64'({mem_req.addr[23:2], mem_req.be,
        mem_req.data & mon_lane()}));
    if (ce && cc_we === 1'b1)
      cmp("cc", pop(q_c), 64'(cond_code));
    if (ce && (done === 1'b1 || priv_trap === 1'b1))
      cmp("pc", pop(q_p), 64'({priv_trap, pc_out}));
  end
  function automatic logic [31:0] mon_lane();
    return {{8{mem_req.be[3]}}, {8{mem_req.be[2]}}, {8{mem_req.be[1]}},
      {8{mem_req.be[0]}}};
  endfunction : mon_lane
  task automatic issue(input op_t o, input logic h, input logic [2:0] r,
    input logic t);
    integer k;
    op = o;
    half_format = h;
    reg_sel = r;
    eff_addr = a;
    lat = 3'($random(seed));
    pc_in = 24'($random(seed));
    q_p.push_back(64'({t, t ? pc_in : pc_in + (h ? 24'h2 : 24'h4)}));
    if (t)
      q_p.push_back(64'({1'b0, pc_in}));
    start = 1'b1;
    @(posedge ref_clk);
    #2;
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && priv_trap !== 1'b1 && k < 300)
    begin
      ce = ($random(seed) & 3) != 0;
      @(posedge ref_clk);
      #2;
      k++;
    end
    ce = 1'b1;
    if (k == 300)
      n_mismatch++;
    if (t)
      @(posedge ref_clk);
  endtask : issue
  task automatic exp_st(input op_t o);
    logic [3:0] b;
    v = (o >= zero_memory_byte_op) ? 32'h0 : gpr[2];
    if (o inside {[store_masked_byte_op:store_masked_word_op]})
      v = v & gpr[4];
    b = 4'hF;
    if (o inside {store_halfword_op, store_masked_halfword_op,
      zero_memory_halfword_op})
    begin
      b = a[1] ? 4'h3 : 4'hC;
      v = {16'h0, v[15:0]} << (a[1] ? 0 : 16);
    end
    if (o inside {store_masked_byte_op, zero_memory_byte_op})
    begin
      b = 4'h8 >> a[1:0];
      v = {24'h0, v[7:0]} << (8 * (3 - a[1:0]));
    end
    if (o inside {store_doubleword_op, zero_memory_doubleword_op})
    begin
      q_m.push_back(64'({a[23:3], 1'b1, b,
        o == store_doubleword_op ? gpr[3] : 32'h0}));
      q_m.push_back(64'({a[23:3], 1'b0, b, v}));
    end
    else
      q_m.push_back(64'({a[23:2], b, v}));
  endtask : exp_st
  initial
  begin
    #500000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    #2;
    rst = 0;
    for (int m = 0; m < 2; m++)
    begin
      extended_mode = m[0];
      ext_index = 4'($random(seed));
      indirect_flag = 1'($random(seed));
      a = 24'($random(seed));
      q_g.push_back(64'({3'h3, 8'h00, ext_index,
        m ? a[19] : indirect_flag, a[18:0]}));
      issue(load_address_op, 0, 3'h3, 0);
    end
    for (int r = 0; r < 8; r += 4)
    begin
      a = r ? 24'h000010 : 24'h000080;
      for (int k = r; k < 8; k++)
        q_g.push_back(64'({k[2:0], 32'h5A5A0000 + 32'(a[7:2] + k - r)}));
      issue(load_register_file_op, 0, r[2:0], 0);
    end
    for (int o = 2; o < 12; o++)
      for (int j = 0; j < 2; j++)
      begin
        gpr[2] = $random(seed);
        gpr[3] = $random(seed);
        gpr[4] = $random(seed);
        a = {18'h0, 6'($random(seed))};
        exp_st(op_t'(o));
        issue(op_t'(o), 0, 3'h2, 0);
      end
    half_instr = '{opcode: 6'h03, dest: 3'h5, src: 3'h5, aug: 4'h0};
    gpr[5] = $random(seed);
    q_g.push_back(64'({3'h5, 32'h0}));
    q_c.push_back(64'(4'h1));
    issue(register_clear_op, 1, 3'h5, 0);
    half_instr = '{opcode: 6'h0B, dest: 3'h1, src: 3'h6, aug: 4'h0};
    for (int i = 0; i < 3; i++)
    begin
      v = i == 0 ? 32'h12345678 : (i == 1 ? 32'h80000001 : 32'h0);
      gpr[6] = v;
      q_g.push_back(64'({3'h1, v}));
      q_c.push_back(64'({1'b0, !v[31] && v != 0, v[31], v == 0}));
      issue(transfer_op, 1, 3'h7, 0);
    end
    // The scratchpad is never written, so its words read back unknown.
    q_g.push_back(64'({3'h1, 32'hX}));
    issue(scratchpad_to_register_op, 1, 3'h0, 0);
    privileged = 0;
    issue(scratchpad_to_register_op, 1, 3'h0, 1);
    repeat (4) @(posedge ref_clk);
    final_report();
  end
endmodule : load_store_zero_exec_unit_test
